// ### verilog/gpio_ports.sv
// Four-port general-purpose I/O block on the data memory bus.
// Function
// - Four ports; unimplemented bits read zero.
// - Output latch holds until rewritten.
// - Per-pin pull-high enable, reset off.
// - Pull-high only on inputs or NMOS outputs.
// - Global bit picks stronger pull-high value.
// - Value select ignored when pull-high off.
// - Port A falling edge wakes halted core.
// - Wake only for inputs while halted.
// - Wake enables on port A bits 7, 4-0.
// - Direction 1 input, 0 output, reset 1.
// - Output read returns latch when control 0.
// - Drive register 0 holds four 2-bit fields.
// - Drive register 1 bits 5-0, reset zero.
// - Drive register 1 fields for port D, bits 1-0 aux.
`default_nettype none
`timescale 1ns/100ps
module gpio_ports (
  input  wire logic            clk_sys,
  input  wire logic            rst_b,
  input  wire logic [7:0]      mem_addr,
  input  wire logic            mem_wr,
  input  wire logic            mem_rd,
  input  wire logic [7:0]      mem_wdata,
  output logic      [7:0]      mem_rdata,
  input  wire logic            input_read_ctrl,
  input  wire logic            halt_mode,
  input  wire logic [3:0][7:0] nmos_sel,
  input  wire logic [3:0][7:0] pin_in,
  output logic      [3:0][7:0] pin_out,
  output logic      [3:0][7:0] pin_oe,
  output logic      [3:0][7:0] pull_on,
  output logic      [3:0][7:0] pull_strong,
  output gpio_pkg::drive_s     drive_level,
  output logic                 wake_req
);

  logic            rst_meta_b;    // First reset release stage.
  logic            rst_sync_b;    // Reset used by the whole block.
  logic [3:0][7:0] level;         // Synchronised pin levels.
  logic [3:0][7:0] dir_rd;        // Direction registers.
  logic [3:0][7:0] pull_rd;       // Pull-high registers.
  logic [3:0][7:0] data_rd;       // Port data read values.
  logic [7:0]      wake_q;        // Port A wake enables.
  logic            pvalue_q;      // Pull-high value select.
  logic [7:0]      drive0_q;      // Drive level register 0.
  logic [7:0]      drive1_q;      // Drive level register 1.
  logic [7:0]      pa_prev_q;     // Port A level one cycle back.
  logic [7:0]      pa_fall;       // Qualified falling edges.
  logic            wake_q_pulse;  // Registered wake request.
  logic [7:0]      rdata_q;       // Registered read data.
  logic [7:0]      rd_mux;        // Read data before the register.

  // True when the bus address hits the given register.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // Reset asserts at once and releases after two clock edges.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // One bank per port, each with its own set of implemented pins.
  for (genvar p = 0; p < gpio_pkg::NUM_PORTS; p++) begin : g_port
    gpio_pkg::pad_s pad;          // Pad controls of this port.
    logic           wr_data_sel;  // Write strobe of the data latch.
    logic           wr_dir_sel;   // Write strobe of the direction register.
    logic           wr_pull_sel;  // Write strobe of the pull-high register.

    // Address decode of this port's three registers.
    assign wr_data_sel = mem_wr && hit(mem_addr, gpio_pkg::ADDR_DATA[p]);
    assign wr_dir_sel  = mem_wr && hit(mem_addr, gpio_pkg::ADDR_DIR[p]);
    assign wr_pull_sel = mem_wr && hit(mem_addr, gpio_pkg::ADDR_PULL[p]);
    gpio_port_bank #(
      .PIN_MASK (gpio_pkg::PORT_MASK[p])
    ) u_bank (
      .clk_sys                (clk_sys),
      .rst_sync_b             (rst_sync_b),
      .wdata                  (mem_wdata),
      .wr_data                (wr_data_sel),
      .wr_dir                 (wr_dir_sel),
      .wr_pull                (wr_pull_sel),
      .input_read_ctrl        (input_read_ctrl),
      .low_volt_pullup_select (pvalue_q),
      .nmos_sel               (nmos_sel[p]),
      .pin_in                 (pin_in[p]),
      .pad                    (pad),
      .level                  (level[p]),
      .dir_rd                 (dir_rd[p]),
      .pull_rd                (pull_rd[p]),
      .data_rd                (data_rd[p])
    );
    assign pin_out[p]     = pad.out & gpio_pkg::PORT_MASK[p];
    assign pin_oe[p]      = pad.oe;
    assign pull_on[p]     = pad.pull_on;
    assign pull_strong[p] = pad.pull_strong;
  end

  // Wake enables exist only for the implemented port A pins.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wake_q <= gpio_pkg::WAKE_RST;
    end else if (mem_wr && hit(mem_addr, gpio_pkg::ADDR_WAKE)) begin
      wake_q <= mem_wdata & gpio_pkg::WAKE_MASK;
    end
  end

  // The global pull-high value select resets to the weaker value.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pvalue_q <= gpio_pkg::PVALUE_RST[0];
    end else if (mem_wr && hit(mem_addr, gpio_pkg::ADDR_PVALUE)) begin
      pvalue_q <= mem_wdata[0];
    end
  end

  // Drive level registers reset to the minimum level.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      drive0_q <= gpio_pkg::DRIVE_RST;
      drive1_q <= gpio_pkg::DRIVE_RST;
    end else if (mem_wr) begin
      if (hit(mem_addr, gpio_pkg::ADDR_DRIVE0)) begin
        drive0_q <= mem_wdata;
      end
      if (hit(mem_addr, gpio_pkg::ADDR_DRIVE1)) begin
        drive1_q <= mem_wdata & gpio_pkg::DRIVE1_MASK;
      end
    end
  end

  // Each 2-bit field steers the source drive of one pin group.
  assign drive_level.pb_hi = drive0_q[7:6];
  assign drive_level.pb_lo = drive0_q[5:4];
  assign drive_level.pa_hi = drive0_q[3:2];
  assign drive_level.pa_lo = drive0_q[1:0];
  assign drive_level.pd_hi = drive1_q[5:4];
  assign drive_level.pd_lo = drive1_q[3:2];
  assign drive_level.aux   = drive1_q[1:0];

  // A falling edge counts only on enabled input pins while halted.
  assign pa_fall = pa_prev_q & ~level[0] & wake_q & dir_rd[0]
                   & {8{halt_mode}};

  // The previous port A level and the wake pulse are kept here.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pa_prev_q    <= 8'h00;
      wake_q_pulse <= 1'b0;
    end else begin
      pa_prev_q    <= level[0];
      wake_q_pulse <= |pa_fall;
    end
  end
  assign wake_req = wake_q_pulse;

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_mux = 8'h00;
    for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
      if (hit(mem_addr, gpio_pkg::ADDR_DATA[p])) begin
        rd_mux = data_rd[p];
      end
      if (hit(mem_addr, gpio_pkg::ADDR_DIR[p])) begin
        rd_mux = dir_rd[p];
      end
      if (hit(mem_addr, gpio_pkg::ADDR_PULL[p])) begin
        rd_mux = pull_rd[p];
      end
    end
    if (hit(mem_addr, gpio_pkg::ADDR_WAKE)) begin
      rd_mux = wake_q;
    end
    if (hit(mem_addr, gpio_pkg::ADDR_PVALUE)) begin
      rd_mux = {7'h00, pvalue_q};
    end
    if (hit(mem_addr, gpio_pkg::ADDR_DRIVE0)) begin
      rd_mux = drive0_q;
    end
    if (hit(mem_addr, gpio_pkg::ADDR_DRIVE1)) begin
      rd_mux = drive1_q;
    end
  end

  // Read data is caught on the read strobe and held until the next read.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rdata_q <= 8'h00;
    end else if (mem_rd) begin
      rdata_q <= rd_mux;
    end
  end
  assign mem_rdata = rdata_q;

  // Checks on the behaviour above, all in the system clock domain.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_b);

  // A falling port A pin 0 under full qualification.
  sequence s_pin0_fall;
    level[0][0] ##1 (!level[0][0] && halt_mode && wake_q[0] && dir_rd[0][0]);
  endsequence

  // A read of the port A data register.
  sequence s_read_pa;
    mem_rd && hit(mem_addr, gpio_pkg::ADDR_DATA[0]);
  endsequence

  a_unimpl_zero: assert property (
    s_read_pa |=> (mem_rdata & ~gpio_pkg::PORT_MASK[0]) == 8'h00)
    else $error("Unimplemented port A bits read nonzero.");

  a_latch_hold: assert property (
    !(mem_wr && hit(mem_addr, gpio_pkg::ADDR_DATA[1])) |=> $stable(pin_out[1]))
    else $error("Port B output latch changed without a write.");

  a_pull_gate: assert property (
    (pull_on[3] & ~(dir_rd[3] | nmos_sel[3])) == 8'h00)
    else $error("Pull-high on a CMOS output pin.");

  a_strong_all: assert property (
    pvalue_q |-> pull_strong[1] == pull_on[1])
    else $error("Stronger pull value not applied.");

  a_strong_gate: assert property (
    (pull_strong[2] & ~pull_on[2]) == 8'h00)
    else $error("Pull value select active on a disabled pull.");

  a_wake_edge: assert property (
    s_pin0_fall |=> wake_req)
    else $error("Qualified falling edge did not wake.");

  a_wake_quiet: assert property (
    !halt_mode |=> !wake_req)
    else $error("Wake request while not halted.");

  a_wake_field: assert property (
    (mem_wr && hit(mem_addr, gpio_pkg::ADDR_WAKE)) |=>
      wake_q == ($past(mem_wdata) & 8'h9f))
    else $error("Wake enable write stored wrong bits.");

  a_dir_write: assert property (
    (mem_wr && hit(mem_addr, gpio_pkg::ADDR_DIR[3])) |=>
      dir_rd[3] == $past(mem_wdata))
    else $error("Port D direction write lost.");

  a_read_latch: assert property (
    (s_read_pa and (!input_read_ctrl && dir_rd[0] == 8'h00)) |=>
      mem_rdata == $past(pin_out[0]))
    else $error("Output pin read did not return the latch.");

  a_read_pin: assert property (
    (s_read_pa and input_read_ctrl) |=> mem_rdata == $past(level[0]))
    else $error("Read with control set did not return pin level.");

  a_drive_top: assert property (
    drive1_q[7:6] == 2'h0)
    else $error("Drive register 1 upper bits not zero.");

  a_drive1_mask: assert property (
    (mem_wr && hit(mem_addr, gpio_pkg::ADDR_DRIVE1)) |=>
      drive1_q == ($past(mem_wdata) & 8'h3f))
    else $error("Drive register 1 write stored wrong bits.");

  a_latch_write: assert property (
    (mem_wr && hit(mem_addr, gpio_pkg::ADDR_DATA[1])) |=>
      pin_out[1] == $past(mem_wdata))
    else $error("Port B output latch write lost.");

  a_pull_write: assert property (
    (mem_wr && hit(mem_addr, gpio_pkg::ADDR_PULL[1])) |=>
      pull_rd[1] == $past(mem_wdata))
    else $error("Port B pull-high write lost.");

  a_pvalue_write: assert property (
    (mem_wr && hit(mem_addr, gpio_pkg::ADDR_PVALUE)) |=>
      pvalue_q == $past(mem_wdata[0]))
    else $error("Pull value select write lost.");

  a_oe_input: assert property (
    (pin_oe & dir_rd) == 32'h0000_0000)
    else $error("Pin configured as input is driven.");

  a_drive0_write: assert property (
    (mem_wr && hit(mem_addr, gpio_pkg::ADDR_DRIVE0)) |=>
      drive_level.pb_hi == $past(mem_wdata[7:6]))
    else $error("Port B upper drive field write lost.");

  a_pd_field: assert property (
    (mem_wr && hit(mem_addr, gpio_pkg::ADDR_DRIVE1)) |=>
      drive_level.pd_lo == $past(mem_wdata[3:2]))
    else $error("Port D lower drive field write lost.");

  a_pc_unimpl: assert property (
    (mem_rd && hit(mem_addr, gpio_pkg::ADDR_DATA[2])) |=>
      mem_rdata[7:4] == 4'h0)
    else $error("Unimplemented port C bits read nonzero.");

  a_dir_read: assert property (
    (mem_rd && hit(mem_addr, gpio_pkg::ADDR_DIR[1])) |=>
      mem_rdata == $past(dir_rd[1]))
    else $error("Port B direction read wrong.");

endmodule
`default_nettype wire

// ### verilog/gpio_pkg.sv
// Package with addresses, masks, reset values and carriers for the ports.
`default_nettype none
package gpio_pkg;

  // Number of ports and width of each port.
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned PORT_W    = 8;

  // Implemented pins of ports A, B, C and D, index 0 is port A.
  localparam logic [3:0][7:0] PORT_MASK = {8'hff, 8'h0f, 8'hff, 8'h9f};

  // Data memory addresses of the per-port registers, index 0 is port A.
  localparam logic [3:0][7:0] ADDR_DATA  = {8'h0c, 8'h08, 8'h04, 8'h00};
  localparam logic [3:0][7:0] ADDR_DIR   = {8'h0d, 8'h09, 8'h05, 8'h01};
  localparam logic [3:0][7:0] ADDR_PULL  = {8'h0e, 8'h0a, 8'h06, 8'h02};

  // Addresses of the shared registers.
  localparam logic [7:0] ADDR_WAKE   = 8'h03;
  localparam logic [7:0] ADDR_PVALUE = 8'h10;
  localparam logic [7:0] ADDR_DRIVE0 = 8'h11;
  localparam logic [7:0] ADDR_DRIVE1 = 8'h12;

  // Implemented bits of the shared registers.
  localparam logic [7:0] WAKE_MASK   = 8'h9f;
  localparam logic [7:0] PVALUE_MASK = 8'h01;
  localparam logic [7:0] DRIVE1_MASK = 8'h3f;

  // Values after reset.
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [7:0] DIR_RST    = 8'hff;
  localparam logic [7:0] PULL_RST   = 8'h00;
  localparam logic [7:0] WAKE_RST   = 8'h00;
  localparam logic [7:0] PVALUE_RST = 8'h00;
  localparam logic [7:0] DRIVE_RST  = 8'h00;

  // Pad controls of one port.
  typedef struct packed {
    logic [7:0] out;          // Level driven while enabled.
    logic [7:0] oe;           // High while the pad is driven.
    logic [7:0] pull_on;      // Internal pull-high connected.
    logic [7:0] pull_strong;  // Stronger pull-high value chosen.
  } pad_s;

  // Source drive levels of the pin groups, each 0 (min) to 3 (max).
  typedef struct packed {
    logic [1:0] pb_hi;   // Port B pins 7 to 4.
    logic [1:0] pb_lo;   // Port B pins 3 to 0.
    logic [1:0] pa_hi;   // Port A pins 7 and 4.
    logic [1:0] pa_lo;   // Port A pins 3 to 0.
    logic [1:0] pd_hi;   // Port D pins 7 to 4.
    logic [1:0] pd_lo;   // Port D pins 3 to 0.
    logic [1:0] aux;     // Last field, passed out unchanged.
  } drive_s;

endpackage
`default_nettype wire

// ### verilog/gpio_port_bank.sv
// One I/O port: output latch, direction, pull-high and input synchroniser.
`default_nettype none
`timescale 1ns/100ps
module gpio_port_bank #(
  parameter logic [7:0] PIN_MASK = 8'hff
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_sync_b,
  input  wire logic [7:0]    wdata,
  input  wire logic          wr_data,
  input  wire logic          wr_dir,
  input  wire logic          wr_pull,
  input  wire logic          input_read_ctrl,
  input  wire logic          low_volt_pullup_select,
  input  wire logic [7:0]    nmos_sel,
  input  wire logic [7:0]    pin_in,
  output gpio_pkg::pad_s     pad,
  output logic      [7:0]    level,
  output logic      [7:0]    dir_rd,
  output logic      [7:0]    pull_rd,
  output logic      [7:0]    data_rd
);

  logic [7:0] data_q;      // Output latch.
  logic [7:0] dir_q;       // Direction, 1 is input.
  logic [7:0] pull_q;      // Pull-high enables.
  logic [7:0] pin_meta_q;  // First synchroniser stage.
  logic [7:0] pin_sync_q;  // Second synchroniser stage.
  logic [7:0] show_pin;    // Pins whose real level is read back.

  // The output latch changes only on a write to it.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      data_q <= gpio_pkg::DATA_RST;
    end else if (wr_data) begin
      data_q <= wdata & PIN_MASK;
    end
  end

  // Direction bits reset to input.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      dir_q <= gpio_pkg::DIR_RST & PIN_MASK;
    end else if (wr_dir) begin
      dir_q <= wdata & PIN_MASK;
    end
  end

  // Pull-high enables reset to off.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pull_q <= gpio_pkg::PULL_RST;
    end else if (wr_pull) begin
      pull_q <= wdata & PIN_MASK;
    end
  end

  // Pins are asynchronous, so they pass two flip-flops first.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Inputs always show the pin; outputs show it only when asked to.
  assign show_pin = dir_q | {8{input_read_ctrl}};
  assign data_rd  = ((show_pin & pin_sync_q) | (~show_pin & data_q))
                    & PIN_MASK;
  assign level    = pin_sync_q & PIN_MASK;
  assign dir_rd   = dir_q;
  assign pull_rd  = pull_q;

  // NMOS outputs drive only low; pull-high only on inputs or NMOS outputs.
  assign pad.out         = data_q;
  assign pad.oe          = ~dir_q & ~(nmos_sel & data_q) & PIN_MASK;
  assign pad.pull_on     = pull_q & (dir_q | nmos_sel) & PIN_MASK;
  assign pad.pull_strong = pad.pull_on
                           & {8{low_volt_pullup_select}};

endmodule
`default_nettype wire

// ### verification/pin_world.sv
// Pin model: device pads, external switches and pull-highs per pin.
`timescale 1ns/100ps
`default_nettype none
module pin_world (
  input  wire logic            clk_sys,
  input  wire logic [3:0][7:0] pin_out,
  input  wire logic [3:0][7:0] pin_oe,
  input  wire logic [3:0][7:0] pull_on,
  input  wire logic [3:0][7:0] sw_en,
  input  wire logic [3:0][7:0] sw_val,
  output logic      [3:0][7:0] pin_lvl
);
  logic [3:0][7:0] last_q;  // Level of the last cycle.

  // Device drive wins, then a switch, then the pull-high.
  // A floating pin shows the inverse of its last level, so no stale value
  // can pass for a real one.
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pin_lvl[p] = (pin_oe[p] & pin_out[p])
        | (~pin_oe[p] & sw_en[p] & sw_val[p])
        | (~pin_oe[p] & ~sw_en[p] & (pull_on[p] | ~last_q[p]));
    end
  end

  // Remember the level for the floating case.
  always_ff @(posedge clk_sys) begin
    last_q <= pin_lvl;
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
// Testbench for the four-port I/O block: registers, pads and wake-up.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic             clk_sys = 1'b0;
  logic             rst_b = 1'b0;
  logic [7:0]       mem_addr = 8'h00;
  logic             mem_wr = 1'b0;
  logic             mem_rd = 1'b0;
  logic [7:0]       mem_wdata = 8'h00;
  logic [7:0]       mem_rdata;
  logic             input_read_ctrl = 1'b0;
  logic             halt_mode = 1'b0;
  logic [3:0][7:0]  nmos_sel = '0;
  logic [3:0][7:0]  sw_en = {4{8'hff}};   // Switches held, steady levels.
  logic [3:0][7:0]  sw_val = {4{8'h5a}};
  logic [3:0][7:0]  pin_lvl;
  logic [3:0][7:0]  pin_out;
  logic [3:0][7:0]  pin_oe;
  logic [3:0][7:0]  pull_on;
  logic [3:0][7:0]  pull_strong;
  gpio_pkg::drive_s drive_level;
  logic             wake_req;
  int               fails = 0;
  int               num_checks = 0;
  int               cyc = 0;
  logic [7:0]       ra [12];  // Register address, mask and reset value.
  logic [7:0]       rm [12];
  logic [7:0]       rr [12];

  gpio_ports i_dut (.clk_sys, .rst_b, .mem_addr, .mem_wr, .mem_rd,
    .mem_wdata, .mem_rdata, .input_read_ctrl, .halt_mode, .nmos_sel,
    .pin_in(pin_lvl), .pin_out, .pin_oe, .pull_on, .pull_strong,
    .drive_level, .wake_req);

  pin_world i_pins (.clk_sys, .pin_out, .pin_oe, .pull_on, .sw_en,
    .sw_val, .pin_lvl);

  // Clock at 20 MHz.
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Prints the verdict and ends the run.
  task automatic results();
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end

  // Compares and counts.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One register write; outputs are settled on return.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    mem_wr <= 1'b1;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge clk_sys);
    mem_wr <= 1'b0;
    #1;
  endtask

  // One register read, compared 1 ns after the read edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    mem_rd <= 1'b1;
    mem_addr <= a;
    @(posedge clk_sys);
    mem_rd <= 1'b0;
    #1;
    chk(mem_rdata, exp);
  endtask

  // Raises port A, drops the pins low in lowv, counts wake pulses.
  task automatic wake_try(input logic [7:0] lowv, input logic [1:0] exp);
    int n;
    n = 0;
    @(posedge clk_sys);
    sw_val[0] <= 8'hff;
    repeat (4) @(posedge clk_sys);
    sw_val[0] <= lowv;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      if (wake_req === 1'b1) n++;
    end
    chk(n, exp);
  endtask

  // Main sequence.
  initial begin
    for (int p = 0; p < 4; p++) begin
      ra[p] = gpio_pkg::ADDR_DIR[p];
      rm[p] = gpio_pkg::PORT_MASK[p];
      rr[p] = gpio_pkg::PORT_MASK[p];
      ra[p+4] = gpio_pkg::ADDR_PULL[p];
      rm[p+4] = gpio_pkg::PORT_MASK[p];
      rr[p+4] = 8'h00;
    end
    ra[8] = gpio_pkg::ADDR_WAKE;
    rm[8] = gpio_pkg::WAKE_MASK;
    ra[9] = gpio_pkg::ADDR_PVALUE;
    rm[9] = gpio_pkg::PVALUE_MASK;
    ra[10] = gpio_pkg::ADDR_DRIVE0;
    rm[10] = 8'hff;
    ra[11] = gpio_pkg::ADDR_DRIVE1;
    rm[11] = gpio_pkg::DRIVE1_MASK;
    for (int i = 8; i < 12; i++) rr[i] = 8'h00;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(pin_oe, 32'h0000_0000);
    chk(pull_on, 32'h0000_0000);
    // Reset values, then every bit written high and read back masked.
    for (int i = 0; i < 12; i++) rd(ra[i], rr[i]);
    for (int p = 0; p < 4; p++) begin
      rd(gpio_pkg::ADDR_DATA[p], 8'h5a & gpio_pkg::PORT_MASK[p]);
    end
    rd(8'h20, 8'h00);
    for (int i = 0; i < 12; i++) wr(ra[i], 8'hff);
    wr(8'h20, 8'hff);
    for (int i = 0; i < 12; i++) rd(ra[i], rm[i]);
    rd(8'h20, 8'h00);
    chk(pull_on, gpio_pkg::PORT_MASK);
    chk(pull_strong, gpio_pkg::PORT_MASK);
    // Open-drain and push-pull outputs on each port.
    for (int p = 0; p < 4; p++) begin
      @(posedge clk_sys);
      nmos_sel[p] <= 8'hff;
      sw_val[p] <= 8'h00;
      wr(gpio_pkg::ADDR_DATA[p], 8'ha5);
      wr(gpio_pkg::ADDR_DIR[p], 8'h00);
      chk(pin_oe[p], 8'h5a & gpio_pkg::PORT_MASK[p]);
      chk(pull_on[p], gpio_pkg::PORT_MASK[p]);
      chk(pull_strong[p], gpio_pkg::PORT_MASK[p]);
      wr(gpio_pkg::ADDR_PULL[p], 8'h00);
      chk(pull_strong[p], 8'h00);
      rd(gpio_pkg::ADDR_DATA[p], 8'ha5 & gpio_pkg::PORT_MASK[p]);
      @(posedge clk_sys);
      input_read_ctrl <= 1'b1;
      rd(gpio_pkg::ADDR_DATA[p], 8'h00);
      @(posedge clk_sys);
      input_read_ctrl <= 1'b0;
      nmos_sel[p] <= 8'h00;
      wr(gpio_pkg::ADDR_PULL[p], 8'hff);
      chk(pull_on[p], 8'h00);
      chk(pin_oe[p], gpio_pkg::PORT_MASK[p]);
      chk(pin_out[p], 8'ha5 & gpio_pkg::PORT_MASK[p]);
    end
    // Drive fields, levels 3, 2, 1, 0, 1, 2, 3 in field order.
    wr(gpio_pkg::ADDR_DRIVE0, 8'he4);
    wr(gpio_pkg::ADDR_DRIVE1, 8'h1b);
    chk(drive_level, {2'h3, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h3});
    // Wake-up from port A falling edges.
    wr(gpio_pkg::ADDR_DIR[0], 8'hff);
    @(posedge clk_sys);
    halt_mode <= 1'b1;
    wake_try(8'hef, 2'h1);
    @(posedge clk_sys);
    halt_mode <= 1'b0;
    wake_try(8'hfe, 2'h0);
    @(posedge clk_sys);
    halt_mode <= 1'b1;
    wr(gpio_pkg::ADDR_WAKE, 8'h01);
    wake_try(8'hef, 2'h0);
    wake_try(8'hfe, 2'h1);
    // An open-drain output pin may not wake, even while halted.
    @(posedge clk_sys);
    nmos_sel[0] <= 8'hff;
    wr(gpio_pkg::ADDR_DIR[0], 8'h00);
    wake_try(8'hfe, 2'h0);
    results();
  end
endmodule
`default_nettype wire
